// ===== identity_and_unlock_subcommands_tb_top.sv
/*
  self-checking bench for the identity and unlock subcommand handler.
  assumes the host model drives the register port; one 50 MHz clock.
*/
`timescale 1ns/1ps
module identity_and_unlock_subcommands_tb_top;
  import iuc_pkg::*;
  localparam logic [15:0] PID = 16'h3c21; // arbitrary value
  localparam logic [15:0] FWV = 16'h0305;
  localparam logic [15:0] BLD = 16'h0719;
  localparam logic [15:0] HWR = 16'h00b2; // arbitrary value
  localparam int          WIN = 16;

  typedef struct packed {
    logic [16:0] code;
    logic [31:0] lo;
    logic [31:0] lo_m;
    logic [15:0] hi;
    logic [3:0]  len;
  } iuc_row_t;

  iuc_row_t rows [3] = '{
    '{17'h00001, {16'h0, PID}, 32'h0000ffff, 16'h0, LEN_PRODUCT_ID},
    '{17'h00002, {FWV[7:0], FWV[15:8], PID[7:0], PID[15:8]},
      32'hffffffff, {BLD[7:0], BLD[15:8]}, LEN_FW_REV},
    '{17'h00003, {16'h0, HWR}, 32'h0000ffff, 16'h0, LEN_HW_REV}};

  logic         clk_i = 1'b0;
  logic         reset_i = 1'b1;
  logic         ce_i = 1'b1;
  iuc_bus_req_t bus;
  logic [31:0]  rd_data_o;
  logic         unrestricted_o;
  logic [7:0]   recovery_o;
  logic         recovery_stb_o;
  logic [31:0]  v;
  int           n_mismatch = 0;
  int           n_tests = 0;
  int           cycles = 0;
  int           n_stb = 0;

  always #10 clk_i = ~clk_i;

  iuc_identity_unlock #(.PRODUCT_ID(PID), .FIRMWARE_REVISION_BLOCK(FWV),
    .BUILD_BCD(BLD), .HW_REVISION(HWR), .KEY_WINDOW(WIN)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .bus_i(bus),
    .rd_data_o(rd_data_o), .unrestricted_o(unrestricted_o),
    .recovery_o(recovery_o), .recovery_stb_o(recovery_stb_o));

  iuc_host_model host (.clk_i(clk_i), .bus_o(bus), .rd_data_i(rd_data_o));

  task automatic give_verdict();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic refused_is(input logic e);
    host.rd(REG_STATUS, v);
    check("refused", {31'h0, v[ST_REFUSED_BIT]}, {31'h0, e});
  endtask

  task automatic run_rows();
    foreach (rows[i])
    begin
      host.cmd(rows[i].code, 32'h0);
      host.rd(REG_RESP_LO, v);
      check("resp_lo", v & rows[i].lo_m, rows[i].lo);
      host.rd(REG_STATUS, v);
      check("resp_len", {28'h0, v[11:8]}, {28'h0, rows[i].len});
      if (rows[i].len == LEN_FW_REV)
      begin
        host.rd(REG_RESP_HI, v);
        check("resp_hi", {16'h0, v[15:0]}, {16'h0, rows[i].hi});
      end
    end
  endtask

  // hang guard
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial
  begin
    tick(4);
    check("reset_mode", {31'h0, unrestricted_o}, 32'h0);
    check("reset_rd", rd_data_o, 32'h0);
    check("reset_recov", {24'h0, recovery_o}, 32'h0);
    reset_i <= 1'b0;
    tick(1);
    run_rows();
    // locked: recovery write and key subcommands are refused
    host.cmd(17'h1009b, 32'h000000a5);
    refused_is(1'b1);
    check("recovery", {24'h0, recovery_o}, 32'h0);
    host.cmd(17'h10035, 32'h2b6c1d5e);
    refused_is(1'b1);
    host.cmd(17'h0009b, 32'h0);
    host.rd(REG_RESP_LO, v);
    check("recov_read", {24'h0, v[7:0]}, 32'h0);
    // wrong step two, interleaved command, expired window
    host.unlock(KEY_STEP1_RESET, 16'h7e37);
    tick(3);
    check("mode_badkey", {31'h0, unrestricted_o}, 32'h0);
    host.wr(REG_CMD, {16'h0, KEY_STEP1_RESET});
    host.cmd(17'h00001, 32'h0);
    host.wr(REG_CMD, {16'h0, KEY_STEP2_RESET});
    tick(3);
    check("mode_between", {31'h0, unrestricted_o}, 32'h0);
    host.wr(REG_CMD, {16'h0, KEY_STEP1_RESET});
    tick(WIN - 1);
    host.wr(REG_CMD, {16'h0, KEY_STEP2_RESET});
    tick(3);
    check("mode_late", {31'h0, unrestricted_o}, 32'h0);
    // correct keys, step two on the last cycle of the window
    host.wr(REG_CMD, {16'h0, KEY_STEP1_RESET});
    tick(WIN - 2);
    host.wr(REG_CMD, {16'h0, KEY_STEP2_RESET});
    check("mode_early", {31'h0, unrestricted_o}, 32'h0);
    tick(2);
    check("mode_open", {31'h0, unrestricted_o}, 32'h1);
    run_rows();
    // recovery byte write, one strobe
    host.cmd(17'h1009b, 32'h000000a5);
    repeat (4)
    begin
      if (recovery_stb_o === 1'b1)
        n_stb++;
      tick(1);
    end
    check("stb_count", n_stb, 32'h1);
    check("recovery", {24'h0, recovery_o}, 32'ha5);
    host.cmd(17'h0009b, 32'h0);
    host.rd(REG_RESP_LO, v);
    check("recov_read", {24'h0, v[7:0]}, 32'ha5);
    host.rd(REG_RECOVERY, v);
    check("recov_reg", v, 32'ha5);
    // key writes and refused accesses in unrestricted mode
    host.cmd(17'h10035, 32'h2b6c1d5e);
    refused_is(1'b0);
    host.cmd(17'h10035, 32'h2b6c0035);
    refused_is(1'b1);
    host.cmd(17'h00035, 32'h0);
    refused_is(1'b1);
    host.cmd(17'h10001, 32'h0);
    refused_is(1'b1);
    check("recov_kept", {24'h0, recovery_o}, 32'ha5);
    host.wr(REG_CMD, 32'h00000077);
    refused_is(1'b1);
    // unmapped read, data stands one cycle
    host.rd(8'h18, v);
    check("unmapped", v, 32'h0);
    host.rd(REG_RECOVERY, v);
    tick(1);
    check("rd_idle", rd_data_o, 32'h0);
    // mid-run reset relocks and restores reset values
    reset_i <= 1'b1;
    tick(2);
    reset_i <= 1'b0;
    tick(1);
    check("rst_mode", {31'h0, unrestricted_o}, 32'h0);
    check("rst_recov", {24'h0, recovery_o}, 32'h0);
    host.rd(REG_STATUS, v);
    check("rst_status", v, 32'h0);
    give_verdict();
  end
endmodule // identity_and_unlock_subcommands_tb_top

// ===== iuc_host_model.sv
/*
  host controller model: issues subcommands and key words over the
  strobe register port, one-cycle strobes, no waits.
  assumes its tasks are entered at a rising clock edge; each task
  returns on one, after an idle cycle that also carries read data.
*/
`timescale 1ns/1ps
module iuc_host_model
  import iuc_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // register port
  output iuc_bus_req_t     bus_o,
  input  wire logic [31:0] rd_data_i
);
  initial bus_o = '0;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_o.addr  <= a;
    bus_o.wdata <= d;
    bus_o.wr    <= 1'b1;
    @(posedge clk_i);
    bus_o.wr    <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus_o.addr <= a;
    bus_o.rd   <= 1'b1;
    @(posedge clk_i);
    bus_o.rd   <= 1'b0;
    @(posedge clk_i);
    d = rd_data_i;
  endtask

  // data word goes first for write-direction subcommands
  task automatic cmd(input logic [16:0] c, input logic [31:0] d);
    if (c[16])
      wr(REG_WDATA, d);
    wr(REG_CMD, {15'h0000, c});
  endtask

  // step one then step two, one idle cycle apart
  task automatic unlock(input logic [15:0] k1, input logic [15:0] k2);
    wr(REG_CMD, {16'h0000, k1});
    wr(REG_CMD, {16'h0000, k2});
  endtask
endmodule // iuc_host_model

// ===== iuc_identity_unlock.sv
/*
  identity and unlock subcommand handler: serves product id, firmware
  revision, hardware revision, unlock key and fault recovery requests.
  assumes a plain strobe register port, one clock, host keeps key timing.
*/
`timescale 1ns/1ps
// Contract
// - product id subcommand returns two bytes, low first, in any mode
// - firmware revision subcommand returns six bytes as three words
// - firmware bytes 0-1 hold product id, high byte first
// - firmware bytes 2-3 hold major and minor version, high byte first
// - firmware bytes 4-5 hold decimal-coded build number, high first
// - hardware revision subcommand returns two bytes in any mode
// - unlock key is a four-byte write, only unrestricted, never readable
// - unrestricted mode entered only after correct key words
// - recovery byte readable when locked, read and write when unrestricted
// - step one is low word, step two high; neither equals a code
module iuc_identity_unlock
  import iuc_pkg::*;
#(
  parameter logic [15:0] PRODUCT_ID  = 16'h5a01, // arbitrary value
  parameter logic [15:0] FIRMWARE_REVISION_BLOCK  = 16'h0102,
  parameter logic [15:0] BUILD_BCD   = 16'h0042,
  parameter logic [15:0] HW_REVISION = 16'h00a1, // arbitrary value
  parameter int          KEY_WINDOW  = KEY_WINDOW_CYCLES
)(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  // register port
  input  wire iuc_bus_req_t bus_i,
  output logic [31:0]       rd_data_o,
  // mode and recovery
  output logic              unrestricted_o,
  output logic [7:0]        recovery_o,
  output logic              recovery_stb_o
);

  iuc_top_state_t s;
  iuc_top_state_t next_s;
  logic           unlock;
  logic           armed;
  logic           cmd_wr;
  logic           dir_write;
  logic [15:0]    code;

  assign cmd_wr    = bus_i.wr && (bus_i.addr == REG_CMD);
  assign dir_write = bus_i.wdata[CMD_DIR_BIT];
  assign code      = bus_i.wdata[15:0];

  // key words arrive as plain command words while locked
  iuc_key_seq #(
    .WINDOW_CYCLES (KEY_WINDOW)
  ) u_key_seq (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .cmd_stb_i   (cmd_wr),
    .cmd_word_i  (code),
    .key_step1_i (s.key1),
    .key_step2_i (s.key2),
    .locked_i    (!s.unrestricted),
    .unlock_o    (unlock),
    .armed_o     (armed)
  );

  always_comb
  begin
    next_s = s;
    next_s.rd_data      = '0;
    next_s.recovery_stb = 1'b0;
    if (unlock)
      next_s.unrestricted = 1'b1;
    if (cmd_wr)
    begin
      next_s.cmd     = bus_i.wdata[16:0];
      next_s.refused = 1'b0;
      case (code)
        SC_PRODUCT_ID:
          if (dir_write)
            next_s.refused = 1'b1;
          else
          begin
            next_s.resp = {32'h0, PRODUCT_ID};
            next_s.len  = LEN_PRODUCT_ID;
          end
        SC_FW_REV:
          if (dir_write)
            next_s.refused = 1'b1;
          else
          begin
            next_s.resp = {swap16(BUILD_BCD),
                           swap16(FIRMWARE_REVISION_BLOCK),
                           swap16(PRODUCT_ID)};
            next_s.len  = LEN_FW_REV;
          end
        SC_HW_REV:
          if (dir_write)
            next_s.refused = 1'b1;
          else
          begin
            next_s.resp = {32'h0, HW_REVISION};
            next_s.len  = LEN_HW_REV;
          end
        SC_UNLOCK_KEY:
          if (dir_write && s.unrestricted &&
              !is_subcommand(s.wdata[15:0]) &&
              !is_subcommand(s.wdata[31:16]) &&
              s.wdata[15:0] != s.wdata[31:16])
          begin
            next_s.key1 = s.wdata[15:0];
            next_s.key2 = s.wdata[31:16];
            next_s.len  = LEN_NONE;
          end
          else
            next_s.refused = 1'b1;
        SC_FAULT_RECOV:
          if (!dir_write)
          begin
            next_s.resp = {40'h0, s.recovery};
            next_s.len  = LEN_RECOV;
          end
          else if (s.unrestricted)
          begin
            next_s.recovery     = s.wdata[7:0];
            next_s.recovery_stb = 1'b1;
            next_s.len          = LEN_NONE;
          end
          else
            next_s.refused = 1'b1;
        default:
          // unknown words while locked may be key words
          next_s.refused = s.unrestricted;
      endcase
    end
    else if (bus_i.wr && bus_i.addr == REG_WDATA)
      next_s.wdata = bus_i.wdata;
    if (bus_i.rd)
    begin
      if (bus_i.addr == REG_CMD)
        next_s.rd_data = {15'h0, s.cmd};
      else if (bus_i.addr == REG_WDATA)
        next_s.rd_data = s.wdata;
      else if (bus_i.addr == REG_RESP_LO)
        next_s.rd_data = s.resp[31:0];
      else if (bus_i.addr == REG_RESP_HI)
        next_s.rd_data = {16'h0, s.resp[47:32]};
      else if (bus_i.addr == REG_STATUS)
      begin
        next_s.rd_data[ST_UNRESTRICTED_BIT]        = s.unrestricted;
        next_s.rd_data[ST_REFUSED_BIT]             = s.refused;
        next_s.rd_data[ST_ARMED_BIT]               = armed;
        next_s.rd_data[ST_LEN_LSB +: 4]            = s.len;
      end
      else if (bus_i.addr == REG_RECOVERY)
        next_s.rd_data = {24'h0, s.recovery};
      else
        next_s.rd_data = '0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s.unrestricted <= 1'b0;
      s.refused      <= 1'b0;
      s.cmd          <= '0;
      s.wdata        <= '0;
      s.resp         <= '0;
      s.len          <= LEN_NONE;
      s.recovery     <= RECOVERY_RESET;
      s.recovery_stb <= 1'b0;
      s.key1         <= KEY_STEP1_RESET;
      s.key2         <= KEY_STEP2_RESET;
      s.rd_data      <= '0;
    end
    else if (ce_i)
      s <= next_s;
  end

  assign rd_data_o      = s.rd_data;
  assign unrestricted_o = s.unrestricted;
  assign recovery_o     = s.recovery;
  assign recovery_stb_o = s.recovery_stb;

  a_pid_low_first: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && !dir_write && code == SC_PRODUCT_ID) |=>
    (s.resp[7:0] == PRODUCT_ID[7:0] && s.resp[15:8] == PRODUCT_ID[15:8]
     && s.len == LEN_PRODUCT_ID))
    else $error("product id response wrong");

  a_fw_length: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && !dir_write && code == SC_FW_REV) |=>
    (s.len == LEN_FW_REV && !s.refused))
    else $error("firmware response length wrong");

  a_fw_legacy_id: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && !dir_write && code == SC_FW_REV) |=>
    (s.resp[7:0] == PRODUCT_ID[15:8] && s.resp[15:8] == PRODUCT_ID[7:0]))
    else $error("firmware legacy id bytes wrong");

  a_firmware_revision_block: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && !dir_write && code == SC_FW_REV) |=>
    (s.resp[23:16] == FIRMWARE_REVISION_BLOCK[15:8] && s.resp[31:24] == FIRMWARE_REVISION_BLOCK[7:0]))
    else $error("firmware version bytes wrong");

  a_fw_build: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && !dir_write && code == SC_FW_REV) |=>
    (s.resp[39:32] == BUILD_BCD[15:8] && s.resp[47:40] == BUILD_BCD[7:0]))
    else $error("firmware build bytes wrong");

  a_hw_revision: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && !dir_write && code == SC_HW_REV) |=>
    (s.resp[15:0] == HW_REVISION && s.len == LEN_HW_REV))
    else $error("hardware revision response wrong");

  a_key_locked: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && code == SC_UNLOCK_KEY && !s.unrestricted) |=>
    (s.refused && s.key1 == $past(s.key1) && s.key2 == $past(s.key2)))
    else $error("unlock key write taken while locked");

  a_key_taken: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && dir_write && code == SC_UNLOCK_KEY && s.unrestricted
     && !is_subcommand(s.wdata[15:0]) && !is_subcommand(s.wdata[31:16])
     && s.wdata[15:0] != s.wdata[31:16]) |=>
    (s.key1 == $past(s.wdata[15:0]) && s.key2 == $past(s.wdata[31:16])
     && !s.refused))
    else $error("valid unlock key write not taken");

  a_key_code_word: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && code == SC_UNLOCK_KEY
     && (is_subcommand(s.wdata[15:0]) || is_subcommand(s.wdata[31:16])))
    |=> (s.refused && s.key1 == $past(s.key1) && s.key2 == $past(s.key2)))
    else $error("key word equal to a subcommand code taken");

  a_unlock_cause: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $rose(s.unrestricted) |-> $past(unlock))
    else $error("unrestricted mode without key sequence");

  a_mode_sticky: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s.unrestricted |=> s.unrestricted)
    else $error("unrestricted mode left without reset");

  a_recov_locked: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && dir_write && code == SC_FAULT_RECOV
     && !s.unrestricted && !unlock) |=>
    (s.recovery == $past(s.recovery) && !s.recovery_stb && s.refused))
    else $error("recovery byte written while locked");

  a_recov_read: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && !dir_write && code == SC_FAULT_RECOV) |=>
    (s.resp[7:0] == $past(s.recovery) && s.resp[47:8] == 40'h0
     && s.len == LEN_RECOV && !s.refused))
    else $error("recovery read response wrong");

  a_recov_write: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && dir_write && code == SC_FAULT_RECOV
     && s.unrestricted) |=>
    (s.recovery == $past(s.wdata[7:0]) && s.recovery_stb && !s.refused))
    else $error("recovery byte write not taken");

  a_stb_cause: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && !(cmd_wr && dir_write && code == SC_FAULT_RECOV)) |=>
    !s.recovery_stb)
    else $error("recovery strobe without a recovery write");

  a_refuse_keeps: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && dir_write && code == SC_FW_REV) |=>
    (s.refused && s.resp == $past(s.resp) && s.len == $past(s.len)))
    else $error("refused access changed the response");

  a_id_write_refused: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && dir_write && code == SC_PRODUCT_ID) |=>
    (s.refused && s.resp == $past(s.resp) && s.len == $past(s.len)))
    else $error("write to product id changed the response");

  a_unknown_refused: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && cmd_wr && s.unrestricted && !is_subcommand(code)) |=>
    s.refused)
    else $error("unknown subcommand not refused");

endmodule // iuc_identity_unlock

// ===== iuc_key_seq.sv
/*
  two-step unlock key sequencer: watches command words in locked mode
  and pulses unlock when step one and step two arrive in order.
  assumes command strobes come from the register port of the top.
*/
`timescale 1ns/1ps
module iuc_key_seq
  import iuc_pkg::*;
#(
  parameter int WINDOW_CYCLES = KEY_WINDOW_CYCLES
)(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // command words
  input  wire logic        cmd_stb_i,
  input  wire logic [15:0] cmd_word_i,
  input  wire logic [15:0] key_step1_i,
  input  wire logic [15:0] key_step2_i,
  input  wire logic        locked_i,
  // result
  output logic             unlock_o,
  output logic             armed_o
);

  localparam logic [31:0] LAST = 32'(WINDOW_CYCLES - 1);

  iuc_key_state_t s;
  iuc_key_state_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.unlock = 1'b0;
    if (!locked_i)
    begin
      next_s.phase = KEY_IDLE;
      next_s.cnt   = '0;
    end
    else
    begin
      case (s.phase)
        KEY_IDLE:
          if (cmd_stb_i && cmd_word_i == key_step1_i)
          begin
            next_s.phase = KEY_ARMED;
            next_s.cnt   = '0;
          end
        KEY_ARMED:
          if (cmd_stb_i)
          begin
            // any other command between the words aborts
            next_s.phase  = KEY_IDLE;
            next_s.unlock = (cmd_word_i == key_step2_i);
          end
          else if (s.cnt == LAST)
            next_s.phase = KEY_IDLE;
          else
            next_s.cnt = s.cnt + 32'h1;
        default:
          next_s.phase = KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s.phase  <= KEY_IDLE;
      s.cnt    <= '0;
      s.unlock <= 1'b0;
    end
    else if (ce_i)
      s <= next_s;
  end

  assign unlock_o = s.unlock;
  assign armed_o  = (s.phase == KEY_ARMED);

  a_window_bound: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (s.phase == KEY_ARMED) |-> (s.cnt <= LAST))
    else $error("key window counter past its limit");

  a_unlock_order: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $rose(s.unlock) |-> $past(s.phase == KEY_ARMED && cmd_stb_i
      && cmd_word_i == key_step2_i && locked_i && ce_i))
    else $error("unlock without step two after step one");

endmodule // iuc_key_seq

// ===== iuc_pkg.sv
/*
  shared constants, carriers and helpers for the identity and unlock
  subcommand block.
  assumes a single 50 MHz clock and a plain strobe register port.
*/
package iuc_pkg;

  // register port carrier
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } iuc_bus_req_t;

  // register offsets
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_WDATA    = 8'h04;
  localparam logic [7:0] REG_RESP_LO  = 8'h08;
  localparam logic [7:0] REG_RESP_HI  = 8'h0c;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_RECOVERY = 8'h14;

  // command register fields
  localparam int CMD_DIR_BIT = 16;

  // status register fields
  localparam int ST_UNRESTRICTED_BIT = 0;
  localparam int ST_REFUSED_BIT      = 1;
  localparam int ST_ARMED_BIT        = 2;
  localparam int ST_LEN_LSB          = 8;

  // subcommand codes
  localparam logic [15:0] SC_PRODUCT_ID  = 16'h0001;
  localparam logic [15:0] SC_FW_REV      = 16'h0002;
  localparam logic [15:0] SC_HW_REV      = 16'h0003;
  localparam logic [15:0] SC_UNLOCK_KEY  = 16'h0035;
  localparam logic [15:0] SC_FAULT_RECOV = 16'h009b;

  // response lengths in bytes
  localparam logic [3:0] LEN_PRODUCT_ID = 4'h2;
  localparam logic [3:0] LEN_FW_REV     = 4'h6;
  localparam logic [3:0] LEN_HW_REV     = 4'h2;
  localparam logic [3:0] LEN_RECOV      = 4'h1;
  localparam logic [3:0] LEN_NONE       = 4'h0;

  // values after reset
  localparam logic [7:0]  RECOVERY_RESET  = 8'h00;
  localparam logic [15:0] KEY_STEP1_RESET = 16'h4a1c;
  localparam logic [15:0] KEY_STEP2_RESET = 16'h7e36;

  // timing
  localparam int CLK_HZ            = 50_000_000;
  localparam int KEY_WINDOW_S      = 5;
  localparam int KEY_WINDOW_CYCLES = KEY_WINDOW_S * CLK_HZ;

  typedef enum logic {KEY_IDLE, KEY_ARMED} iuc_key_phase_t;

  typedef struct packed {
    iuc_key_phase_t phase;
    logic [31:0]    cnt;
    logic           unlock;
  } iuc_key_state_t;

  typedef struct packed {
    logic        unrestricted;
    logic        refused;
    logic [16:0] cmd;
    logic [31:0] wdata;
    logic [47:0] resp;
    logic [3:0]  len;
    logic [7:0]  recovery;
    logic        recovery_stb;
    logic [15:0] key1;
    logic [15:0] key2;
    logic [31:0] rd_data;
  } iuc_top_state_t;

  function automatic logic is_subcommand(input logic [15:0] w);
    return (w == SC_PRODUCT_ID) || (w == SC_FW_REV) ||
           (w == SC_HW_REV) || (w == SC_UNLOCK_KEY) ||
           (w == SC_FAULT_RECOV);
  endfunction

  function automatic logic [15:0] swap16(input logic [15:0] w);
    return {w[7:0], w[15:8]};
  endfunction

endpackage
